// ### ccs_can_node.sv
`timescale 1ns/1ps
// Other nodes stay recessive, so the wired-AND bus echoes our own bits
module ccs_can_node
(
   input wire logic can_tx_i,
   output logic can_rx_o
);
   assign can_rx_o = can_tx_i;
endmodule // ccs_can_node

// ### ccs_pkg.sv
package ccs_pkg;
   localparam int NBUF = 32;
   localparam logic [3:0] ADDR_CORE_CTRL = 4'h0;
   localparam logic [3:0] ADDR_TX_PEND = 4'h1;
   localparam logic [3:0] ADDR_TX_ADD = 4'h2;
   localparam logic [3:0] ADDR_TX_CANCEL = 4'h3;
   localparam logic [3:0] ADDR_TX_DONE = 4'h4;
   localparam logic [3:0] ADDR_CFG = 4'h5;
   localparam int BIT_INIT = 0;
   localparam int BIT_CCE = 1;
   localparam int BIT_CSR = 4;
   localparam int BIT_CSA = 3;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [7:0] TX_FRAME_CYCLES = 8'h3f;
   localparam logic [31:0] DEAD_DATA = 32'hdead_beef;
   typedef enum logic [1:0] {CCS_IDLE, CCS_SCAN, CCS_SEND} ccs_state_t;
endpackage

// ### ccs_sync.sv
`timescale 1ns/1ps
module ccs_sync
   import ccs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic d_i,
   output logic q_o
);
   logic s1_ff, s2_ff, s3_ff;
   // Change accepted only when stages two and three agree
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         q_o <= 1'b1;
      end
      else if (ce_i)
      begin
         s1_ff <= d_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff)
            q_o <= s3_ff;
      end
endmodule // ccs_sync

// ### ccs_top.sv
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - While running, the transmit handler keeps scanning the buffers for outstanding requests.
// - Each outstanding request has its own pending bit, and the scan picks candidates from those bits.
// - Writing a one into the add-request register sets that pending bit unless config change is enabled, and the transmission starts once init is clear.
// - On a clock stop request the device, once idle, sets both the init and clock stop acknowledge bits.
// - Init reads zero only after the device has really left initialization.
// - With configuration change enabled, protected configuration writes are accepted.
module ccs_top
   import ccs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic can_rx_i,
   output logic can_tx_o,
   output logic [31:0] cfg_o
);
   logic ack_ff;
   logic init_ff;
   logic cce_ff;
   logic csr_ff;
   logic csa_ff;
   wire [NBUF-1:0] pend_ff;
   wire [NBUF-1:0] done_ff;
   logic [31:0] cfg_ff;
   logic [4:0] idx_ff;
   logic [7:0] cnt_ff;
   ccs_state_t st_ff;

   logic [31:0] nxt_rdata;
   logic rx_s;
   logic busy;
   logic wr;
   logic rd;

   logic ctl_wr;
   logic add_wr;
   logic cancel_wr;
   logic done_wr;
   logic cfg_wr;
   logic stop_ok;
   logic fin;
   logic last_idx;
   logic cnt_zero;

   ccs_sync u_rx_sync (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .d_i(can_rx_i),
      .q_o(rx_s)
   );

   // One wait cycle per access: the read mux is registered on the first edge,
   // and a write lands only on the edge where waitrequest is seen low
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
   assign wr = avs_write_i & ack_ff & ce_i;
   assign rd = avs_read_i & ~ack_ff & ce_i;

   assign ctl_wr = wr && (avs_address_i == ADDR_CORE_CTRL);
   assign add_wr = wr && (avs_address_i == ADDR_TX_ADD) && !cce_ff;
   assign cancel_wr = wr && (avs_address_i == ADDR_TX_CANCEL);
   assign done_wr = wr && (avs_address_i == ADDR_TX_DONE);
   assign cfg_wr = wr && (avs_address_i == ADDR_CFG) && init_ff && cce_ff;

   assign busy = (st_ff != CCS_IDLE);
   assign stop_ok = csr_ff && !busy && !csa_ff;
   assign cnt_zero = (cnt_ff == 8'h00);
   assign last_idx = (idx_ff == 5'h1f);
   assign fin = (st_ff == CCS_SEND) && cnt_zero && rx_s;
   assign cfg_o = cfg_ff;

   // Ack drops on the accept edge, so a held request is served again every second cycle
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         ack_ff <= 1'b0;
      else if (ce_i)
         ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;

   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      case (avs_address_i)
         ADDR_CORE_CTRL:
         begin
            nxt_rdata[BIT_INIT] = init_ff;
            nxt_rdata[BIT_CCE] = cce_ff;
            nxt_rdata[BIT_CSA] = csa_ff;
            nxt_rdata[BIT_CSR] = csr_ff;
         end
         ADDR_TX_PEND:
            nxt_rdata = pend_ff;
         ADDR_TX_DONE:
            nxt_rdata = done_ff;
         ADDR_CFG:
            nxt_rdata = cfg_ff;
         ADDR_TX_ADD, ADDR_TX_CANCEL:
            nxt_rdata = 32'h0000_0000;
         default:
            nxt_rdata = DEAD_DATA;
      endcase
   end

   // Registered so the data already stands at the edge that completes the read
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         avs_readdata_o <= 32'h0000_0000;
      else if (rd)
         avs_readdata_o <= nxt_rdata;

   // Stop request follows the last core control write
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         csr_ff <= 1'b0;
      else if (ce_i && ctl_wr)
         csr_ff <= avs_writedata_i[BIT_CSR];

   // Init starts set; it cannot be left while a stop is still requested, and the
   // single write that enables config change and drops an acknowledged stop keeps it set
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         init_ff <= 1'b1;
      else if (ce_i)
      begin
         if (ctl_wr)
         begin
            if (!avs_writedata_i[BIT_CSR])
               init_ff <= avs_writedata_i[BIT_INIT] | (csa_ff & avs_writedata_i[BIT_CCE]);
         end
         else if (stop_ok)
            init_ff <= 1'b1;
      end

   // Acknowledge is raised only once the handler has gone idle
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         csa_ff <= 1'b0;
      else if (ce_i)
      begin
         if (ctl_wr)
         begin
            if (!avs_writedata_i[BIT_CSR])
               csa_ff <= 1'b0;
         end
         else if (stop_ok)
            csa_ff <= 1'b1;
      end

   // Enable only holds while init is set
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         cce_ff <= 1'b0;
      else if (ce_i)
      begin
         if (!init_ff)
            cce_ff <= 1'b0;
         else if (ctl_wr)
            cce_ff <= avs_writedata_i[BIT_CCE];
      end

   // Protected configuration
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         cfg_ff <= CFG_RESET;
      else if (cfg_wr)
         cfg_ff <= avs_writedata_i;

   // Scan finishes before init can freeze it, so enabling cce mid-scan cannot stall the handler
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         st_ff <= CCS_IDLE;
      else if (ce_i)
         case (st_ff)
            CCS_IDLE:
               if (!init_ff && |pend_ff)
                  st_ff <= CCS_SCAN;
            CCS_SCAN:
               if (pend_ff[idx_ff])
                  st_ff <= CCS_SEND;
               else if (last_idx)
                  st_ff <= CCS_IDLE;
            CCS_SEND:
               if (cnt_zero || !pend_ff[idx_ff])
                  st_ff <= CCS_IDLE;
            default:
               st_ff <= CCS_IDLE;
         endcase

   // Buffer index walks one step per cycle while no candidate is found
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         idx_ff <= 5'h00;
      else if (ce_i)
         case (st_ff)
            CCS_IDLE:
               idx_ff <= 5'h00;
            CCS_SCAN:
               if (!pend_ff[idx_ff] && !last_idx)
                  idx_ff <= idx_ff + 5'h01;
            default:
               idx_ff <= idx_ff;
         endcase

   // Frame length counter
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         cnt_ff <= 8'h00;
      else if (ce_i)
         case (st_ff)
            CCS_SCAN:
               if (pend_ff[idx_ff])
                  cnt_ff <= TX_FRAME_CYCLES;
            CCS_SEND:
               if (!cnt_zero && pend_ff[idx_ff])
                  cnt_ff <= cnt_ff - 8'h01;
            default:
               cnt_ff <= cnt_ff;
         endcase

   // Line rests recessive outside a frame and as soon as a frame is cancelled
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         can_tx_o <= 1'b1;
      else if (ce_i)
      begin
         if (st_ff == CCS_SEND && !cnt_zero && pend_ff[idx_ff])
            can_tx_o <= cnt_ff[0];
         else
            can_tx_o <= 1'b1;
      end

   // One pending flop per buffer; an add in the same cycle as a completion
   // or a cancel wins, so a fresh request is never lost
   for (genvar b = 0; b < NBUF; b++)
   begin : g_pend
      logic pnd_ff;
      logic hit;
      logic add_b;
      logic cancel_b;
      assign hit = fin && (idx_ff == 5'(b));
      assign add_b = add_wr && avs_writedata_i[b];
      assign cancel_b = cancel_wr && avs_writedata_i[b];
      assign pend_ff[b] = pnd_ff;

      always_ff @(posedge mclk_i or negedge rstn_i)
         if (!rstn_i)
            pnd_ff <= 1'b0;
         else if (ce_i)
         begin
            if (add_b)
               pnd_ff <= 1'b1;
            else if (hit || cancel_b)
               pnd_ff <= 1'b0;
         end
   end

   // One done flop per buffer; a completion beats a software clear in the same cycle
   for (genvar b = 0; b < NBUF; b++)
   begin : g_done
      logic dn_ff;
      logic hit;
      logic add_b;
      logic clr_b;
      assign hit = fin && (idx_ff == 5'(b));
      assign add_b = add_wr && avs_writedata_i[b];
      assign clr_b = done_wr && avs_writedata_i[b];
      assign done_ff[b] = dn_ff;

      always_ff @(posedge mclk_i or negedge rstn_i)
         if (!rstn_i)
            dn_ff <= 1'b0;
         else if (ce_i)
         begin
            if (add_b)
               dn_ff <= 1'b0;
            else if (hit)
               dn_ff <= 1'b1;
            else if (clr_b)
               dn_ff <= 1'b0;
         end
   end
endmodule // ccs_top

// ### ccs_top_sva.sv
`timescale 1ns/1ps
module ccs_top_sva
   import ccs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic can_rx_i,
   input wire logic can_tx_o,
   input wire logic [31:0] cfg_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   logic ctl_rd;
   assign ctl_rd = avs_read_i && !avs_waitrequest_o && avs_address_i == ADDR_CORE_CTRL;
   one_wait_a: assert property (ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not answered after one wait");
   unmapped_rd_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > ADDR_CFG |->
      avs_readdata_o == DEAD_DATA) else $error("unmapped read data wrong");
   ack_init_a: assert property (ctl_rd && avs_readdata_o[BIT_CSA] |-> avs_readdata_o[BIT_INIT])
      else $error("stop ack without init");
   ack_req_a: assert property (ctl_rd && avs_readdata_o[BIT_CSA] |-> avs_readdata_o[BIT_CSR])
      else $error("stop ack without request");
   cce_init_a: assert property (ctl_rd && avs_readdata_o[BIT_CCE] |-> avs_readdata_o[BIT_INIT])
      else $error("config enable outside init");
   cfg_cause_a: assert property (!$stable(cfg_o) |-> $past(avs_write_i && !avs_waitrequest_o &&
      avs_address_i == ADDR_CFG) && cfg_o == $past(avs_writedata_i)) else $error("config changed without write");
   ce_freeze_a: assert property (!ce_i |=> $stable(cfg_o) && $stable(can_tx_o))
      else $error("state moved while frozen");
endmodule // ccs_top_sva

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
   import ccs_pkg::*;
;
   logic mclk_i, rstn_i, ce_i, avs_read_i, avs_write_i, can_rx_i, can_tx_o, avs_waitrequest_o;
   logic [3:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, cfg_o, rdat;
   int error_cnt = 0;
   int n_checks = 0;
   ccs_top dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .can_rx_i(can_rx_i),
      .can_tx_o(can_tx_o), .cfg_o(cfg_o));
   ccs_can_node node (.can_tx_i(can_tx_o), .can_rx_o(can_rx_i));
   initial
   begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Waitrequest is judged at the edge, before that edge's updates land
   task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      avs_read_i <= r;
      avs_write_i <= !r;
      avs_address_i <= a;
      avs_writedata_i <= d;
      @(posedge mclk_i iff avs_waitrequest_o === 1'b0);
      rdat = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b1, a, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
      int i;
      i = 0;
      do
      begin
         bus(1'b1, a, 32'h0);
         i++;
      end while ((rdat & m) !== v && i < 300);
      chk(rdat & m, v);
   endtask
   initial
   begin
      int k;
      rstn_i = 1'b0;
      ce_i = 1'b1;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 4'h0;
      avs_writedata_i = 32'h0;
      repeat (5) @(posedge mclk_i);
      rstn_i <= 1'b1;
      ce_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      ce_i <= 1'b1;
      rd(ADDR_CORE_CTRL, 32'h0000_0001);
      rd(4'hf, DEAD_DATA);
      wr(ADDR_CFG, 32'h5a5a_5a5a);
      rd(ADDR_CFG, CFG_RESET);
      wr(ADDR_CORE_CTRL, 32'h0);
      poll(ADDR_CORE_CTRL, 32'h1, 32'h0);
      wr(ADDR_TX_ADD, 32'h8000_0001);
      rd(ADDR_TX_PEND, 32'h8000_0001);
      k = 0;
      while (can_tx_o !== 1'b0 && k < 100)
      begin
         @(posedge mclk_i);
         k++;
      end
      chk(32'(can_tx_o), 32'h0);
      poll(ADDR_TX_PEND, 32'hffff_ffff, 32'h0);
      rd(ADDR_TX_DONE, 32'h8000_0001);
      wr(ADDR_TX_DONE, 32'hffff_ffff);
      rd(ADDR_TX_DONE, 32'h0);
      wr(ADDR_TX_ADD, 32'h0000_00ff);
      wr(ADDR_TX_CANCEL, 32'hffff_ffff);
      rd(ADDR_TX_PEND, 32'h0);
      wr(ADDR_CORE_CTRL, 32'h10);
      poll(ADDR_CORE_CTRL, 32'h9, 32'h9);
      wr(ADDR_CORE_CTRL, 32'h1);
      rd(ADDR_CORE_CTRL, 32'h1);
      wr(ADDR_CORE_CTRL, 32'h0);
      poll(ADDR_CORE_CTRL, 32'h1, 32'h0);
      wr(ADDR_CORE_CTRL, 32'h10);
      poll(ADDR_CORE_CTRL, 32'h9, 32'h9);
      wr(ADDR_CORE_CTRL, 32'h3);
      rd(ADDR_CORE_CTRL, 32'h3);
      wr(ADDR_CFG, 32'h5a5a_0001);
      rd(ADDR_CFG, 32'h5a5a_0001);
      chk(cfg_o, 32'h5a5a_0001);
      wrap_up();
   end
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      error_cnt++;
      wrap_up();
   end
endmodule // tb_top
bind ccs_top ccs_top_sva chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .can_rx_i(can_rx_i),
   .can_tx_o(can_tx_o), .cfg_o(cfg_o));
